// file: shared/sfc_pkg.sv
package sfc_pkg;

  // instruction codes
  localparam logic [7:0] OP_WRITE_PERMIT_SET = 8'h06;
  localparam logic [7:0] OP_WRITE_PERMIT_CLEAR = 8'h04;
  localparam logic [7:0] OP_OTP_ENTRY = 8'h3A;
  localparam logic [7:0] OP_STATUS_READ = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
  localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE = 8'h32;
  localparam logic [7:0] OP_SECTOR_WIPE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_WIPE = 8'h52;
  localparam logic [7:0] OP_BLOCK_WIPE = 8'hD8;
  localparam logic [7:0] OP_CHIP_WIPE_A = 8'hC7;
  localparam logic [7:0] OP_CHIP_WIPE_B = 8'h60;
  localparam logic [7:0] OP_SLEEP_ENTRY = 8'hB9;
  localparam logic [7:0] OP_WAKE = 8'hAB;
  localparam logic [7:0] OP_MAKER_DEVICE_ID = 8'h90;
  localparam logic [7:0] OP_SOFT_RESET_ARM = 8'h66;
  localparam logic [7:0] OP_SOFT_RESET = 8'h99;
  localparam logic [7:0] OP_FULL_QUAD_ENTRY = 8'h38;
  localparam logic [7:0] OP_QUAD_EXIT = 8'hFF;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3B;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hBB;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6B;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'hEB;
  localparam logic [7:0] ID_SELECT_MAKER_FIRST = 8'h00;

  // status register layout
  localparam int ST_BUSY = 0;
  localparam int ST_WRITE_PERMIT = 1;
  localparam int ST_BOOT_LOCK_ENABLE = 3;
  localparam int ST_LOCK_GRANULE = 4;
  localparam int ST_LOCK_END = 6;
  localparam logic [7:0] STATUS_OTP_MASK = 8'h58;
  localparam logic [7:0] STATUS_VOLATILE_MASK = 8'hA4;
  localparam logic [7:0] STATUS_RESET = 8'h00;

  // frame lengths, in bits before the data-out phase and in whole bytes
  localparam logic [11:0] HDR_ADDR_READ = 12'h020;
  localparam logic [11:0] HDR_FAST_READ = 12'h028;
  localparam logic [11:0] HDR_STATUS_READ = 12'h008;
  localparam logic [11:0] HDR_ID_READ = 12'h020;
  localparam logic [11:0] NBITS_SATURATE = 12'hFF0;
  localparam logic [8:0] BYTES_OPCODE_ONLY = 9'h001;
  localparam logic [8:0] BYTES_STATUS_WRITE = 9'h002;
  localparam logic [8:0] BYTES_ERASE = 9'h004;
  localparam logic [8:0] BYTES_PROGRAM_MIN = 9'h005;
  localparam logic [8:0] BYTES_PROGRAM_HEADER = 9'h004;

  // length of the modelled internal write cycle, in system clocks
  localparam logic [15:0] BUSY_CYCLES = 16'h0100;

  typedef enum logic [2:0] {
    SFC_EXEC_PAGE_WRITE,
    SFC_EXEC_SECTOR_WIPE,
    SFC_EXEC_HALF_BLOCK_WIPE,
    SFC_EXEC_BLOCK_WIPE,
    SFC_EXEC_CHIP_WIPE
  } sfc_exec_kind_t;

  typedef struct packed {
    logic valid;
    sfc_exec_kind_t kind;
    logic [23:0] addr;
    logic [8:0] nbytes;
  } sfc_exec_t;

  typedef struct packed {
    logic quad;
    logic sleeping;
    logic [7:0] status;
  } sfc_link_cfg_t;

  typedef enum logic [1:0] {
    SFC_ST_DESELECTED,
    SFC_ST_SELECTED,
    SFC_ST_DECODE
  } sfc_state_t;

endpackage

// file: hw/sfc_frontend.sv
`timescale 1ns/1ps
module sfc_frontend #(
  parameter logic [7:0] MAKER_CODE = 8'hA5, // arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'h5A // arbitrary value
) (
  // system side
  input wire logic clock,
  input wire logic rst_b,
  // serial link
  input wire logic link_clock,
  input wire logic cs_b,
  input wire logic [3:0] dq_in,
  output logic [3:0] dq_out,
  output logic [3:0] dq_oe_b,
  // array back end, on the link clock
  input wire logic [7:0] array_byte,
  output logic [23:0] rd_addr,
  // executed commands and state
  output sfc_pkg::sfc_exec_t exec,
  output logic [7:0] status,
  output logic otp_mode,
  output logic quad_mode,
  output logic sleeping
);

  function automatic logic is_array_read(input logic [7:0] op);
    is_array_read = (op == sfc_pkg::OP_READ) || (op == sfc_pkg::OP_FAST_READ) ||
                    (op == sfc_pkg::OP_DUAL_OUT_READ) || (op == sfc_pkg::OP_DUAL_IO_READ) ||
                    (op == sfc_pkg::OP_QUAD_OUT_READ) || (op == sfc_pkg::OP_QUAD_IO_READ);
  endfunction

  function automatic logic [11:0] header_bits(input logic [7:0] op);
    if (op == sfc_pkg::OP_READ) begin
      header_bits = sfc_pkg::HDR_ADDR_READ;
    end else if (is_array_read(op)) begin
      header_bits = sfc_pkg::HDR_FAST_READ;
    end else if (op == sfc_pkg::OP_STATUS_READ) begin
      header_bits = sfc_pkg::HDR_STATUS_READ;
    end else begin
      header_bits = sfc_pkg::HDR_ID_READ;
    end
  endfunction

  // ---------------- link clock domain ----------------
  logic link_clr;
  logic fresh;
  logic frame_tog;
  logic [7:0] shreg;
  logic [11:0] nbits;
  logic [7:0] frame_bytes [0:3];
  sfc_pkg::sfc_link_cfg_t link_cfg;
  sfc_pkg::sfc_link_cfg_t cfg_shadow;

  // select high marks the next edge as a frame's first
  always_ff @(posedge link_clock or posedge cs_b or posedge link_clr) begin
    if (cs_b || link_clr) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  wire sfc_pkg::sfc_link_cfg_t cfg_now = fresh ? cfg_shadow : link_cfg;
  wire [7:0] sh_base = fresh ? 8'h00 : shreg;
  wire [11:0] cnt_base = fresh ? 12'h000 : nbits;
  wire [11:0] bit_step = cfg_now.quad ? 12'h004 : 12'h001;
  wire [7:0] next_shreg = cfg_now.quad ? {sh_base[3:0], dq_in} : {sh_base[6:0], dq_in[0]};
  wire [11:0] next_nbits = (cnt_base >= sfc_pkg::NBITS_SATURATE) ? cnt_base : cnt_base + bit_step;
  wire byte_done = (next_nbits[2:0] == 3'h0);
  wire [8:0] done_index = next_nbits[11:3] - 9'h001;
  wire [7:0] next_addr_lo = (byte_done && done_index == 9'h003) ? next_shreg : frame_bytes[3];
  wire [11:0] hdr_next = header_bits((byte_done && done_index == 9'h000) ? next_shreg : frame_bytes[0]);
  wire [11:0] rel_next = (next_nbits >= hdr_next) ? next_nbits - hdr_next : 12'h000;
  wire [23:0] next_rd_addr = {frame_bytes[1], frame_bytes[2], next_addr_lo} + {15'h0000, rel_next[11:3]};

  always_ff @(posedge link_clock or posedge link_clr) begin
    if (link_clr) begin
      frame_tog <= 1'b0;
      nbits <= 12'h000;
      shreg <= 8'h00;
    end else begin
      frame_tog <= fresh ? ~frame_tog : frame_tog;
      nbits <= next_nbits;
      shreg <= next_shreg;
    end
  end

  // the first edge of a frame captures the settled configuration
  always_ff @(posedge link_clock) begin
    if (fresh) begin
      link_cfg <= cfg_shadow;
    end
    if (byte_done && done_index < 9'h004) begin
      frame_bytes[done_index[1:0]] <= next_shreg;
    end
  end

  always_ff @(posedge link_clock or posedge cs_b or posedge link_clr) begin
    if (cs_b || link_clr) begin
      rd_addr <= 24'h000000;
    end else begin
      rd_addr <= next_rd_addr;
    end
  end

  // data-out phase
  wire [7:0] op_link = frame_bytes[0];
  wire [11:0] hdr_now = header_bits(op_link);
  wire [11:0] rel_now = nbits - hdr_now;
  wire [2:0] out_pos = rel_now[2:0];
  wire odd_byte = rel_now[3];
  wire busy_link = link_cfg.status[sfc_pkg::ST_BUSY];
  wire maker_first = (frame_bytes[3] == sfc_pkg::ID_SELECT_MAKER_FIRST);
  wire array_out = is_array_read(op_link) && !busy_link && !link_cfg.sleeping;
  wire status_out = (op_link == sfc_pkg::OP_STATUS_READ) && !link_cfg.sleeping;
  wire wake_out = (op_link == sfc_pkg::OP_WAKE);
  wire id_out = (op_link == sfc_pkg::OP_MAKER_DEVICE_ID) && !link_cfg.sleeping;
  wire out_active = !fresh && (nbits >= hdr_now) && (array_out || status_out || wake_out || id_out);
  wire [7:0] id_byte = (maker_first ^ odd_byte) ? MAKER_CODE : DEVICE_CODE;
  wire [7:0] out_byte = array_out ? array_byte :
                        status_out ? link_cfg.status :
                        wake_out ? DEVICE_CODE : id_byte;

  // select high or reset drops the drivers at once, even inside a byte
  always_ff @(negedge link_clock or posedge cs_b or posedge link_clr) begin
    if (cs_b || link_clr) begin
      dq_out <= 4'h0;
      dq_oe_b <= 4'hF;
    end else if (!out_active) begin
      dq_out <= 4'h0;
      dq_oe_b <= 4'hF;
    end else if (link_cfg.quad) begin
      dq_out <= out_pos[2] ? out_byte[3:0] : out_byte[7:4];
      dq_oe_b <= 4'h0;
    end else begin
      dq_out <= {2'b00, out_byte[3'h7 - out_pos], 1'b0};
      dq_oe_b <= 4'hD;
    end
  end

  // ---------------- system clock domain ----------------
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  logic cs_level;
  logic tog_s1;
  logic tog_s2;
  logic tog_s3;
  logic seen_tog;
  logic write_permit_latch;
  logic soft_reset_armed;
  logic [15:0] busy_count;
  sfc_pkg::sfc_state_t state;
  sfc_pkg::sfc_state_t next_state;

  // select passes three flops; a change counts once the last two agree
  always_ff @(posedge clock) begin
    cs_s1 <= cs_b;
    cs_s2 <= cs_s1;
    cs_s3 <= cs_s2;
    tog_s1 <= frame_tog;
    tog_s2 <= tog_s1;
    tog_s3 <= tog_s2;
  end

  wire cs_agree = (cs_s2 == cs_s3);
  wire next_cs_level = cs_agree ? cs_s3 : cs_level;

  always_comb begin
    next_state = state;
    case (state)
      sfc_pkg::SFC_ST_DESELECTED: begin
        if (!next_cs_level) begin
          next_state = sfc_pkg::SFC_ST_SELECTED;
        end
      end
      sfc_pkg::SFC_ST_SELECTED: begin
        if (next_cs_level) begin
          next_state = sfc_pkg::SFC_ST_DECODE;
        end
      end
      default: begin
        next_state = sfc_pkg::SFC_ST_DESELECTED;
      end
    endcase
  end

  // frame record is quiet here: the link clock stands while select is high
  wire decode = (state == sfc_pkg::SFC_ST_DECODE) && (tog_s2 == tog_s3) && (tog_s3 != seen_tog);
  wire [7:0] op = frame_bytes[0];
  wire [8:0] nbytes = nbits[11:3];
  wire aligned = (nbits[2:0] == 3'h0);
  wire busy = status[sfc_pkg::ST_BUSY];
  wire one_byte = aligned && (nbytes == sfc_pkg::BYTES_OPCODE_ONLY);
  wire may_write = aligned && write_permit_latch && !busy;
  wire is_page = (op == sfc_pkg::OP_PAGE_WRITE) || (op == sfc_pkg::OP_QUAD_PAGE_WRITE && !quad_mode);
  wire is_erase = (op == sfc_pkg::OP_SECTOR_WIPE) || (op == sfc_pkg::OP_HALF_BLOCK_WIPE) ||
                  (op == sfc_pkg::OP_BLOCK_WIPE);
  wire is_chip = (op == sfc_pkg::OP_CHIP_WIPE_A) || (op == sfc_pkg::OP_CHIP_WIPE_B);
  wire awake = !sleeping;
  wire do_page = decode && awake && is_page && may_write && (nbytes >= sfc_pkg::BYTES_PROGRAM_MIN);
  wire do_erase = decode && awake && is_erase && may_write && (nbytes == sfc_pkg::BYTES_ERASE);
  wire do_chip = decode && awake && is_chip && write_permit_latch && !busy && one_byte;
  wire do_stat_wr = decode && awake && (op == sfc_pkg::OP_STATUS_WRITE) && may_write &&
                    (nbytes == sfc_pkg::BYTES_STATUS_WRITE);
  wire do_wel_set = decode && awake && (op == sfc_pkg::OP_WRITE_PERMIT_SET) && one_byte;
  wire do_wel_clr = decode && awake && (op == sfc_pkg::OP_WRITE_PERMIT_CLEAR) && one_byte;
  wire do_otp = decode && awake && (op == sfc_pkg::OP_OTP_ENTRY) && one_byte;
  wire do_sleep = decode && awake && (op == sfc_pkg::OP_SLEEP_ENTRY) && one_byte;
  wire do_wake = decode && (op == sfc_pkg::OP_WAKE) && (nbytes >= sfc_pkg::BYTES_OPCODE_ONLY);
  wire do_arm = decode && awake && (op == sfc_pkg::OP_SOFT_RESET_ARM) && one_byte;
  wire do_reset = decode && awake && (op == sfc_pkg::OP_SOFT_RESET) && one_byte && soft_reset_armed;
  wire do_quad_on = decode && awake && (op == sfc_pkg::OP_FULL_QUAD_ENTRY) && one_byte;
  wire do_quad_off = decode && awake && quad_mode && (op == sfc_pkg::OP_QUAD_EXIT) && nbits == 12'h008;
  wire start_cycle = do_page || do_erase || do_chip || do_stat_wr;

  wire [7:0] wr_data = frame_bytes[1];
  // lock bits go from 0 to 1 only in OTP mode; only rst_b clears them
  wire [7:0] lock_bits = status & sfc_pkg::STATUS_OTP_MASK;
  wire [7:0] next_lock = otp_mode ? (lock_bits | (wr_data & sfc_pkg::STATUS_OTP_MASK)) : lock_bits;
  wire [7:0] next_vol = otp_mode ? (status & sfc_pkg::STATUS_VOLATILE_MASK) :
                        (wr_data & sfc_pkg::STATUS_VOLATILE_MASK);
  wire next_busy = start_cycle || (busy && busy_count > 16'h0001);
  wire next_wel = do_reset ? 1'b0 :
                  (start_cycle || do_wel_clr) ? 1'b0 :
                  do_wel_set ? 1'b1 : write_permit_latch;
  wire [7:0] status_base = do_reset ? lock_bits :
                           do_stat_wr ? (next_lock | next_vol) : status;
  wire [7:0] next_status = {status_base[7:2], next_wel, next_busy && !do_reset};

  wire sfc_pkg::sfc_exec_kind_t exec_kind = is_page ? sfc_pkg::SFC_EXEC_PAGE_WRITE :
                                            (op == sfc_pkg::OP_SECTOR_WIPE) ? sfc_pkg::SFC_EXEC_SECTOR_WIPE :
                                            (op == sfc_pkg::OP_HALF_BLOCK_WIPE) ? sfc_pkg::SFC_EXEC_HALF_BLOCK_WIPE :
                                            (op == sfc_pkg::OP_BLOCK_WIPE) ? sfc_pkg::SFC_EXEC_BLOCK_WIPE :
                                            sfc_pkg::SFC_EXEC_CHIP_WIPE;
  wire [8:0] data_bytes = is_page ? nbytes - sfc_pkg::BYTES_PROGRAM_HEADER : 9'h000;
  wire sfc_pkg::sfc_exec_t next_exec = '{valid: do_page || do_erase || do_chip, kind: exec_kind,
                                         addr: {frame_bytes[1], frame_bytes[2], frame_bytes[3]},
                                         nbytes: data_bytes};

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      link_clr <= 1'b1;
      cs_level <= 1'b1;
      state <= sfc_pkg::SFC_ST_DESELECTED;
      seen_tog <= 1'b0;
      status <= sfc_pkg::STATUS_RESET;
      write_permit_latch <= 1'b0;
      otp_mode <= 1'b0;
      quad_mode <= 1'b0;
      sleeping <= 1'b0;
      soft_reset_armed <= 1'b0;
      busy_count <= 16'h0000;
      exec <= '0;
      cfg_shadow <= '0;
    end else begin
      link_clr <= 1'b0;
      cs_level <= next_cs_level;
      state <= next_state;
      seen_tog <= (state == sfc_pkg::SFC_ST_DECODE) ? tog_s3 : seen_tog;
      status <= next_status;
      write_permit_latch <= next_wel;
      otp_mode <= (do_otp || otp_mode) && !do_wel_clr && !do_reset;
      quad_mode <= (do_quad_on || quad_mode) && !do_quad_off;
      sleeping <= (do_sleep || sleeping) && !do_wake;
      soft_reset_armed <= decode ? do_arm : soft_reset_armed;
      busy_count <= start_cycle ? sfc_pkg::BUSY_CYCLES :
                    do_reset ? 16'h0000 :
                    (busy_count != 16'h0000) ? busy_count - 16'h0001 : busy_count;
      exec <= next_exec;
      // only refreshed between frames, so the link never sees it move
      if (state == sfc_pkg::SFC_ST_DESELECTED) begin
        cfg_shadow <= '{quad: quad_mode, sleeping: sleeping, status: status};
      end
    end
  end

endmodule

// file: tb/sfc_frontend_sva.sv
`timescale 1ns/1ps
module sfc_frontend_sva (
  // system side
  input wire logic clock,
  input wire logic rst_b,
  // serial link
  input wire logic link_clock,
  input wire logic cs_b,
  input wire logic [3:0] dq_in,
  input wire logic [3:0] dq_out,
  input wire logic [3:0] dq_oe_b,
  // array back end
  input wire logic [7:0] array_byte,
  input wire logic [23:0] rd_addr,
  // results
  input wire sfc_pkg::sfc_exec_t exec,
  input wire logic [7:0] status,
  input wire logic otp_mode,
  input wire logic quad_mode,
  input wire logic sleeping
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [15:0] busy_run;
  // length of the current internal cycle
  always_ff @(posedge clock) begin
    if (!rst_b || !status[0]) busy_run <= 16'h0000;
    else busy_run <= busy_run + 16'h0001;
  end
  oe_idle_a: assert property (cs_b && $past(cs_b) |-> dq_oe_b == 4'hF)
    else $error("output enabled while deselected");
  addr_idle_a: assert property (cs_b && $past(cs_b) |-> rd_addr == 24'h000000)
    else $error("read address held while deselected");
  exec_pulse_a: assert property (exec.valid |=> !exec.valid)
    else $error("command executed twice");
  lock_gate_a: assert property ((status & 8'h58) != ($past(status) & 8'h58) |-> $past(otp_mode))
    else $error("lock bits changed outside otp mode");
  lock_keep_a: assert property ((($past(status) & ~status) & 8'h58) == 8'h00)
    else $error("lock bit cleared");
  exec_cause_a: assert property (exec.valid |-> $past(status[1], 2) &&
    !$past(status[0], 2) && !$past(sleeping, 2))
    else $error("command executed without permit or while busy");
  busy_len_a: assert property (busy_run <= sfc_pkg::BUSY_CYCLES + 16'h0008)
    else $error("internal cycle too long");
  page_bytes_a: assert property (exec.valid |->
    (exec.kind == sfc_pkg::SFC_EXEC_PAGE_WRITE) == (exec.nbytes != 9'h000))
    else $error("data byte count wrong for command kind");
  quad_oe_a: assert property (dq_oe_b == 4'h0 |-> quad_mode)
    else $error("four lines driven outside quad mode");
endmodule
bind sfc_frontend sfc_frontend_sva u_sfc_frontend_sva (.clock, .rst_b, .link_clock, .cs_b, .dq_in, .dq_out,
  .dq_oe_b, .array_byte, .rd_addr, .exec, .status, .otp_mode, .quad_mode, .sleeping);

// file: tb/sfc_host_model.sv
`timescale 1ns/1ps
module sfc_host_model (
  // link towards the device
  output logic link_clock,
  output logic cs_b,
  output logic [3:0] dq_in,
  input wire logic [3:0] dq_out
);
  logic [63:0] rx;
  initial begin
    link_clock = 1'b0;
    cs_b = 1'b1;
    dq_in = 4'hF;
    rx = 64'h0;
  end
  // clock stands low between frames
  task automatic frame(input logic [63:0] tx, input int nbits, input bit quad);
    int i;
    cs_b = 1'b0;
    #45;
    for (i = 0; i < nbits; i += (quad ? 4 : 1)) begin
      dq_in = quad ? tx[63 - i -: 4] : {3'b111, tx[63 - i]};
      #15 link_clock = 1'b1;
      rx = quad ? {rx[59:0], dq_out} : {rx[62:0], dq_out[1]};
      #15 link_clock = 1'b0;
    end
    #20 cs_b = 1'b1;
    // released line: show the inverse, never the last value
    dq_in = ~dq_in;
    #110;
  endtask
endmodule

// file: tb/sfc_frontend_tb_top.sv
`timescale 1ns/1ps
module sfc_frontend_tb_top;
  localparam logic [7:0] MK = 8'hC3; // arbitrary value
  localparam logic [7:0] DV = 8'h96; // arbitrary value
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic link_clock, cs_b;
  logic [3:0] dq_in, dq_out, dq_oe_b;
  logic [7:0] array_byte = 8'h00;
  logic [23:0] rd_addr;
  sfc_pkg::sfc_exec_t exec, last_exec;
  logic [7:0] status;
  logic otp_mode, quad_mode, sleeping;
  logic [63:0] rx;
  int num_errors = 0;
  int total_checks = 0;
  int n_exec = 0;
  assign rx = u_sfc_host_model.rx;
  always #4 clock = ~clock;
  always @(posedge clock) begin
    array_byte <= rd_addr[7:0] ^ 8'h3C;
    if (exec.valid === 1'b1) begin
      n_exec++;
      last_exec = exec;
    end
  end
  sfc_frontend #(.MAKER_CODE(MK), .DEVICE_CODE(DV)) u_sfc_frontend (.clock, .rst_b, .link_clock, .cs_b,
    .dq_in, .dq_out, .dq_oe_b, .array_byte, .rd_addr, .exec, .status, .otp_mode, .quad_mode, .sleeping);
  sfc_host_model u_sfc_host_model (.link_clock, .cs_b, .dq_in, .dq_out);
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic f(input logic [63:0] v, input int w, input int n = -1, input bit q = 1'b0);
    u_sfc_host_model.frame(v << (64 - w), n < 0 ? w : n, q);
  endtask
  task automatic idle;
    int i;
    for (i = 0; i < 400 && status[0] !== 1'b0; i++) @(negedge clock);
    if (i == 400) begin
      num_errors++;
      complete_run();
    end
  endtask
  task automatic t_basic;
    chk("status", 8'h00, status);
    chk("oe idle", 4'hF, dq_oe_b);
    f(8'h06, 8, 7);
    chk("wel partial", 0, status[1]);
    f(8'h06, 8);
    chk("wel", 1, status[1]);
    f(8'h05, 8, 32);
    chk("status rd", {3{8'h02}}, rx[23:0]);
    f(8'h05, 8, 13);
    chk("oe release", 4'hF, dq_oe_b);
    f(48'h030000100000, 48);
    chk("array rd", 16'h2C2D, rx[15:0]);
    f(8'h04, 8);
    chk("wel clear", 0, status[1]);
    $display("test basic done");
  endtask
  task automatic t_prog;
    int n0;
    f(8'h06, 8);
    n0 = n_exec;
    f(32'h02000100, 32);
    f(48'h020001005A00, 48, 44);
    f(32'h32000100, 32);
    chk("short prog", n0, n_exec);
    chk("wel kept", 1, status[1]);
    f(40'h020001005A, 40);
    chk("kind", sfc_pkg::SFC_EXEC_PAGE_WRITE, last_exec.kind);
    chk("addr", 24'h000100, last_exec.addr);
    chk("nbytes", 1, last_exec.nbytes);
    chk("busy", 1, status[0]);
    f(8'h06, 8);
    f(32'h20000000, 32);
    chk("busy exec", n0 + 1, n_exec);
    idle();
    $display("test program done");
  endtask
  task automatic t_wipe;
    logic [7:0] ops [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    int i, w, n0;
    for (i = 0; i < 5; i++) begin
      w = i < 3 ? 32 : 8;
      n0 = n_exec;
      f(8'h06, 8);
      f({ops[i], 24'h012345} >> (32 - w), w, w + 8);
      if (w == 32) f({ops[i], 24'h012345} >> 8, 24);
      chk("wipe bad", n0, n_exec);
      chk("wel kept", 1, status[1]);
      f({ops[i], 24'h012345} >> (32 - w), w);
      chk("wipe run", n0 + 1, n_exec);
      chk("wipe kind", i < 3 ? i + 1 : 4, last_exec.kind);
      if (w == 32) chk("wipe addr", 24'h012345, last_exec.addr);
      idle();
    end
    $display("test wipe done");
  endtask
  task automatic t_lock;
    f(8'h06, 8);
    f(16'h01FF, 16);
    f(40'h0300001000, 40);
    chk("busy rd", 8'h00, rx[7:0]);
    idle();
    chk("st plain", 8'hA4, status);
    f(8'h3A, 8);
    chk("otp", 1, otp_mode);
    f(8'h06, 8);
    f(16'h0158, 16);
    idle();
    chk("st lock", 8'hFC, status);
    f(8'h04, 8);
    chk("otp exit", 0, otp_mode);
    f(8'h06, 8);
    f(16'h0100, 16);
    idle();
    chk("st keep", 8'h58, status);
    $display("test lock done");
  endtask
  task automatic t_sleep;
    f(8'hB9, 8);
    chk("sleep", 1, sleeping);
    f(8'h06, 8);
    chk("wel asleep", 0, status[1]);
    f(8'hAB, 8, 40);
    chk("wake id", DV, rx[7:0]);
    chk("awake", 0, sleeping);
    f(8'hB9, 8);
    f(8'hAB, 8, 4);
    chk("short wake", 1, sleeping);
    f(8'hAB, 8);
    chk("wake", 0, sleeping);
    f(32'h90000000, 32, 48);
    chk("id 00", {MK, DV}, rx[15:0]);
    f(32'h90000001, 32, 48);
    chk("id 01", {DV, MK}, rx[15:0]);
    $display("test sleep done");
  endtask
  task automatic t_modes;
    f(8'h66, 8);
    f(8'h06, 8);
    f(8'h99, 8);
    chk("rst cancel", 1, status[1]);
    f(8'h66, 8);
    f(8'h99, 8);
    chk("rst", 8'h58, status);
    f(8'h38, 8);
    chk("quad", 1, quad_mode);
    f(8'h05, 8, 16, 1'b1);
    chk("quad st", 8'h58, rx[7:0]);
    f(8'hFF, 8, 8, 1'b1);
    chk("quad exit", 0, quad_mode);
    @(posedge clock) rst_b <= 1'b0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (4) @(posedge clock);
    chk("reset", 8'h00, status);
    $display("test modes done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    repeat (5) @(posedge clock);
    t_basic();
    t_prog();
    t_wipe();
    t_lock();
    t_sleep();
    t_modes();
    complete_run();
  end
endmodule
